// File: verilog/rdtc_cfg.svh
// Register offsets, field positions, reset values and timing counts of the reload down timer.
`ifndef RDTC_CFG_SVH
`define RDTC_CFG_SVH
`define RDTC_ADDR_W        20
`define RDTC_OFF_RUN       20'hf0240
`define RDTC_OFF_IO        20'hf0241
`define RDTC_OFF_MODE      20'hf0242
`define RDTC_OFF_GATE      20'hf0243
`define RDTC_RST_BYTE      8'h00
`define RDTC_CNT_INIT      16'hffff
`define RDTC_CNT_ZERO      16'h0000
// Run/status register fields.
`define RDTC_B_UNDF        5
`define RDTC_B_EDGF        4
`define RDTC_B_STOP        2
`define RDTC_B_CSTF        1
`define RDTC_B_START       0
// I/O control register fields.
`define RDTC_B_GATE_HI     7
`define RDTC_B_GATE_LO     6
`define RDTC_B_FILT_HI     5
`define RDTC_B_FILT_LO     4
`define RDTC_B_OUT_EN      2
`define RDTC_B_POL         0
// Mode register fields.
`define RDTC_B_SRC_HI      6
`define RDTC_B_SRC_LO      4
`define RDTC_B_BOTH        3
`define RDTC_B_MODE_HI     2
`define RDTC_B_MODE_LO     0
// Gate select register fields.
`define RDTC_B_GPOL        2
`define RDTC_B_GTMR_HI     1
`define RDTC_B_GTMR_LO     0
// Filter sample dividers and prescaler divisions.
`define RDTC_DIV8          5'd7
`define RDTC_DIV32         5'd31
`define RDTC_DIV2          5'd1
`define RDTC_MATCH_N       3
`endif

// File: verilog/rdtc_pkg.sv
// Types of the reload down timer control block.
package rdtc_pkg;
    typedef enum logic [2:0] {
        RDTC_MODE_TIMER  = 3'h0,
        RDTC_MODE_PULSE  = 3'h1,
        RDTC_MODE_EVENT  = 3'h2,
        RDTC_MODE_WIDTH  = 3'h3,
        RDTC_MODE_PERIOD = 3'h4
    } rdtc_mode_t;
    typedef enum logic [2:0] {
        RDTC_SRC_CLK    = 3'h0,
        RDTC_SRC_DIV8   = 3'h1,
        RDTC_SRC_DIV2   = 3'h3,
        RDTC_SRC_LOSC   = 3'h4,
        RDTC_SRC_ELINK  = 3'h5,
        RDTC_SRC_SUBCLK = 3'h6
    } rdtc_src_t;
    typedef enum logic [1:0] {
        RDTC_RUN_IDLE = 2'b00,
        RDTC_RUN_ON   = 2'b01,
        RDTC_RUN_OFF  = 2'b11
    } rdtc_run_t;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [19:0] addr;
        logic [7:0] wdata;
    } rdtc_bus_t;
    typedef struct packed {
        logic gate_source_a;
        logic gate_source_b;
        logic gate_source_c;
        logic gate_source_d;
    } rdtc_gates_t;
endpackage : rdtc_pkg

// File: verilog/rdtc_filter.sv
// Input noise filter: three equal samples at a chosen rate before the value is taken.
`timescale 1ns/1ps
`default_nettype none
`include "rdtc_cfg.svh"
module rdtc_filter
    import rdtc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       clk_en,
    input  wire logic [1:0] sel,
    input  wire logic       din,
    output logic            dout
);
    logic [4:0] div;
    logic [4:0] next_div;
    logic [2:0] hist;
    logic [2:0] next_hist;
    logic       held;
    logic       next_held;
    logic       tick;

    always_comb begin
        next_div  = div + 5'd1;
        unique case (sel)
            2'b01:   tick = 1'b1;
            2'b10:   tick = (div[2:0] == 3'(`RDTC_DIV8));
            default: tick = (div == `RDTC_DIV32);
        endcase
        next_hist = tick ? {hist[1:0], din} : hist;
        next_held = held;
        if (hist == 3'h7) begin
            next_held = 1'b1;
        end else if (hist == 3'h0) begin
            next_held = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div  <= 5'h00;
            hist <= 3'h0;
            held <= 1'b0;
        end else if (clk_en) begin
            div  <= next_div;
            hist <= next_hist;
            held <= next_held;
        end
    end

    // Filter off passes the synchronised input straight through.
    assign dout = (sel == 2'b00) ? din : held;
endmodule : rdtc_filter
`default_nettype wire

// File: verilog/rdtc_timer.sv
// Control, status, mode and pin logic of the 16-bit reload down timer.
`timescale 1ns/1ps
`default_nettype none
`include "rdtc_cfg.svh"
module rdtc_timer
    import rdtc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    input  wire rdtc_bus_t   bus,
    output logic [7:0]       rdata,
    input  wire logic        low_speed_tick,
    input  wire logic        sub_clock_tick,
    input  wire logic        event_link_unit,
    input  wire logic        gate_interrupt_pin,
    input  wire rdtc_gates_t gates,
    input  wire logic        bidir_timer_pin_i,
    output logic             bidir_timer_pin_o,
    output logic             bidir_timer_pin_oe,
    input  wire logic        port_level,
    output logic             timer_out_pin,
    output logic [15:0]      reload_counter,
    output logic             underflow_irq,
    output logic             edge_irq
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [7:0] meta;
    logic [7:0] sync;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta <= 8'h00;
            sync <= 8'h00;
        end else if (clk_en) begin
            meta <= {low_speed_tick, sub_clock_tick, gate_interrupt_pin, bidir_timer_pin_i,
                     gates.gate_source_a, gates.gate_source_b, gates.gate_source_c, gates.gate_source_d};
            sync <= meta;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] io_ctl;
    logic [7:0] mode_ctl;
    logic [7:0] gate_sel;
    logic       underflow_flag;
    logic       active_edge_flag;
    logic       count_run_request;
    logic       count_status_flag;
    logic [7:0] next_io_ctl;
    logic [7:0] next_mode_ctl;
    logic [7:0] next_gate_sel;
    logic       next_underflow_flag;
    logic       next_active_edge_flag;
    logic       next_count_run_request;
    logic       next_count_status_flag;

    logic wr_run;
    logic force_stop;
    logic wr_mode;
    logic uf_event;
    logic edge_event;
    logic src_tick;
    assign wr_run     = bus.wr && (bus.addr == `RDTC_OFF_RUN);
    assign wr_mode    = bus.wr && (bus.addr == `RDTC_OFF_MODE);
    assign force_stop = wr_run && bus.wdata[`RDTC_B_STOP];

    rdtc_mode_t mode;
    rdtc_src_t  src;
    logic       pol;
    assign mode = rdtc_mode_t'(mode_ctl[`RDTC_B_MODE_HI:`RDTC_B_MODE_LO]);
    assign src  = rdtc_src_t'(mode_ctl[`RDTC_B_SRC_HI:`RDTC_B_SRC_LO]);
    assign pol  = io_ctl[`RDTC_B_POL];

    always_comb begin
        next_io_ctl   = io_ctl;
        next_mode_ctl = mode_ctl;
        next_gate_sel = gate_sel;
        if (bus.wr && bus.addr == `RDTC_OFF_IO) begin
            next_io_ctl = bus.wdata & 8'hf5;
        end
        if (wr_mode) begin
            next_mode_ctl = bus.wdata & 8'h7f;
        end
        if (bus.wr && bus.addr == `RDTC_OFF_GATE) begin
            next_gate_sel = bus.wdata & 8'h07;
        end
        // Hardware set wins over a software clear in the same cycle.
        next_underflow_flag = underflow_flag;
        next_active_edge_flag = active_edge_flag;
        if (wr_run && !bus.wdata[`RDTC_B_UNDF]) begin
            next_underflow_flag = 1'b0;
        end
        if (wr_run && !bus.wdata[`RDTC_B_EDGF]) begin
            next_active_edge_flag = 1'b0;
        end
        if (uf_event) begin
            next_underflow_flag = 1'b1;
        end
        if (edge_event) begin
            next_active_edge_flag = 1'b1;
        end
        next_count_run_request = count_run_request;
        next_count_status_flag = count_status_flag;
        if (wr_run) begin
            next_count_run_request = bus.wdata[`RDTC_B_START];
        end
        if (src_tick) begin
            next_count_status_flag = count_run_request;
        end
        if (force_stop) begin
            next_count_run_request = 1'b0;
            next_count_status_flag = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            io_ctl            <= `RDTC_RST_BYTE;
            mode_ctl          <= `RDTC_RST_BYTE;
            gate_sel          <= `RDTC_RST_BYTE;
            underflow_flag    <= 1'b0;
            active_edge_flag  <= 1'b0;
            count_run_request <= 1'b0;
            count_status_flag <= 1'b0;
        end else if (clk_en) begin
            io_ctl            <= next_io_ctl;
            mode_ctl          <= next_mode_ctl;
            gate_sel          <= next_gate_sel;
            underflow_flag    <= next_underflow_flag;
            active_edge_flag  <= next_active_edge_flag;
            count_run_request <= next_count_run_request;
            count_status_flag <= next_count_status_flag;
        end
    end

    // ------------------------------------------------------------
    // Count source
    // ------------------------------------------------------------
    logic [2:0] pre;
    logic       link_q;
    logic       ls_q;
    logic       sub_q;
    logic       pin_f;
    logic       pin_q;
    logic       pin_edge;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pre    <= 3'h0;
            link_q <= 1'b0;
            ls_q   <= 1'b0;
            sub_q  <= 1'b0;
            pin_q  <= 1'b0;
        end else if (clk_en) begin
            pre    <= pre + 3'h1;
            link_q <= event_link_unit;
            ls_q   <= sync[7];
            sub_q  <= sync[6];
            pin_q  <= pin_f;
        end
    end

    rdtc_filter u_filter (
        .clk     (clk),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .sel     (io_ctl[`RDTC_B_FILT_HI:`RDTC_B_FILT_LO]),
        .din     (sync[4]),
        .dout    (pin_f)
    );

    // Rising edge when polarity 0, falling when 1; both edges when selected.
    assign pin_edge = mode_ctl[`RDTC_B_BOTH] ? (pin_f ^ pin_q)
                    : (pol ? (pin_q & ~pin_f) : (pin_f & ~pin_q));

    logic gate_lvl;
    logic gate_ok;
    always_comb begin
        unique case (gate_sel[`RDTC_B_GTMR_HI:`RDTC_B_GTMR_LO])
            2'b00:   gate_lvl = sync[3];
            2'b01:   gate_lvl = sync[2];
            2'b10:   gate_lvl = sync[1];
            default: gate_lvl = sync[0];
        endcase
        unique case (io_ctl[`RDTC_B_GATE_HI:`RDTC_B_GATE_LO])
            2'b00:   gate_ok = 1'b1;
            2'b01:   gate_ok = (sync[5] == gate_sel[`RDTC_B_GPOL]);
            2'b10:   gate_ok = (gate_lvl == gate_sel[`RDTC_B_GPOL]);
            default: gate_ok = 1'b0;
        endcase
        if (mode == RDTC_MODE_EVENT) begin
            src_tick = pin_edge && gate_ok;
        end else begin
            unique case (src)
                RDTC_SRC_CLK:    src_tick = 1'b1;
                RDTC_SRC_DIV8:   src_tick = (pre == 3'h7);
                RDTC_SRC_DIV2:   src_tick = pre[0];
                RDTC_SRC_LOSC:   src_tick = sync[7] & ~ls_q;
                RDTC_SRC_ELINK:  src_tick = event_link_unit & ~link_q;
                RDTC_SRC_SUBCLK: src_tick = sync[6] & ~sub_q;
                default:         src_tick = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Counter and pulse outputs
    // ------------------------------------------------------------
    logic [15:0] next_counter;
    logic        out_lvl;
    logic        next_out_lvl;
    logic        active;
    logic        in_level;
    assign active   = count_status_flag && src_tick;
    assign in_level = (pin_f == pol);
    assign uf_event = active && (reload_counter == `RDTC_CNT_ZERO) && (mode != RDTC_MODE_WIDTH || in_level);
    assign edge_event = count_status_flag &&
        (((mode == RDTC_MODE_WIDTH) && pin_q == pol && pin_f != pol) ||
         ((mode == RDTC_MODE_PERIOD) && (pol ? (pin_q & ~pin_f) : (pin_f & ~pin_q))));

    always_comb begin
        next_counter = reload_counter;
        next_out_lvl = out_lvl;
        if (active && (mode != RDTC_MODE_WIDTH || in_level)) begin
            next_counter = reload_counter - 16'h0001;
        end
        if (uf_event) begin
            next_out_lvl = ~out_lvl;
        end
        if (force_stop) begin
            next_counter = `RDTC_CNT_INIT;
        end
        if (force_stop || wr_mode) begin
            next_out_lvl = pol;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reload_counter <= `RDTC_CNT_INIT;
            out_lvl        <= 1'b0;
        end else if (clk_en) begin
            reload_counter <= next_counter;
            out_lvl        <= next_out_lvl;
        end
    end

    assign timer_out_pin      = io_ctl[`RDTC_B_OUT_EN] ? out_lvl : port_level;
    assign bidir_timer_pin_o  = ~out_lvl;
    assign bidir_timer_pin_oe = (mode == RDTC_MODE_PULSE);
    assign underflow_irq      = uf_event;
    assign edge_irq           = edge_event;

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata <= 8'h00;
        end else if (clk_en && bus.rd) begin
            unique case (bus.addr)
                `RDTC_OFF_RUN:  rdata <= {2'b00, underflow_flag, active_edge_flag, 1'b0,
                                          1'b0, count_status_flag, count_run_request} & 8'h33 | 8'h00;
                `RDTC_OFF_IO:   rdata <= io_ctl;
                `RDTC_OFF_MODE: rdata <= mode_ctl;
                `RDTC_OFF_GATE: rdata <= gate_sel;
                default:        rdata <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_stop_clears: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && force_stop |=> !count_run_request && !count_status_flag)
        else $error("force stop left run state set");
    a_stop_loads: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && force_stop |=> reload_counter == 16'hffff)
        else $error("force stop did not load counter");
    a_uf_sets: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && uf_event |=> underflow_flag)
        else $error("underflow flag not set");
    a_edge_sets: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && edge_event |=> active_edge_flag)
        else $error("edge flag not set");
    a_flag_keep: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && wr_run && bus.wdata[5] && underflow_flag |=> underflow_flag)
        else $error("write of one cleared flag");
    a_status_sync: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && !src_tick && !force_stop |=> $stable(count_status_flag))
        else $error("status changed off source tick");
    a_mode_init: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && wr_mode |=> out_lvl == $past(pol))
        else $error("mode write did not reinit output");
    a_port_pass: assert property (@(posedge clk) disable iff (sys_rst)
        !io_ctl[2] |-> timer_out_pin == port_level)
        else $error("disabled output not port");
    c_underflow: cover property (@(posedge clk) uf_event);
    c_edge: cover property (@(posedge clk) edge_event);
    c_stop: cover property (@(posedge clk) force_stop && count_status_flag);
endmodule : rdtc_timer
`default_nettype wire

// File: dv/rdtc_pin_model.sv
// Behavioural model of the external device on the timer's two-way event pin.
`timescale 1ns/1ps
`default_nettype none
module rdtc_pin_model (
    input  wire logic clk,
    input  wire logic pin_o,
    input  wire logic pin_oe,
    output logic      pin_i
);
    logic drive;

    // The timer wins the wire while it drives it; otherwise the source sets the level.
    assign pin_i = pin_oe ? pin_o : drive;

    initial drive = 1'b0;

    // Pulses of w high cycles, each followed by a quiet low gap.
    task automatic pulse(input int n, input int w);
        repeat (n) begin
            @(posedge clk);
            drive <= 1'b1;
            repeat (w) @(posedge clk);
            drive <= 1'b0;
            repeat (8) @(posedge clk);
        end
    endtask : pulse
endmodule : rdtc_pin_model
`default_nettype wire

// File: dv/reload_down_timer_control_bench.sv
// Self-checking bench of the reload down timer control block.
`timescale 1ns/1ps
`default_nettype none
`include "rdtc_cfg.svh"
module reload_down_timer_control_bench
    import rdtc_pkg::*;
;
    typedef struct packed {
        logic [19:0] addr;
        logic [7:0]  wdata;
        logic [7:0]  rexp;
    } rdtc_row_t;

    logic        clk;
    logic        sys_rst;
    rdtc_bus_t   bus;
    logic [7:0]  rdata;
    logic        pin_i;
    logic        pin_o;
    logic        pin_oe;
    logic        gate_interrupt_pin;
    logic        low_speed_tick;
    rdtc_gates_t gates;
    logic        port_level;
    logic        timer_out_pin;
    logic [15:0] reload_counter;
    logic        underflow_irq;
    logic        edge_irq;
    logic [7:0]  d;
    logic [15:0] c0;
    int          num_errors;
    int          checked;
    int          uf_cnt;
    int          ed_cnt;
    int          i;

    // Reserved bits read as zero, so the readback drops them.
    rdtc_row_t rows [13] = '{
        '{`RDTC_OFF_IO, 8'hff, 8'hf5}, '{`RDTC_OFF_IO, 8'h00, 8'h00},
        '{`RDTC_OFF_MODE, 8'hff, 8'h7f}, '{`RDTC_OFF_MODE, 8'h13, 8'h13},
        '{`RDTC_OFF_MODE, 8'h33, 8'h33}, '{`RDTC_OFF_MODE, 8'h40, 8'h40},
        '{`RDTC_OFF_MODE, 8'h50, 8'h50}, '{`RDTC_OFF_MODE, 8'h60, 8'h60},
        '{`RDTC_OFF_MODE, 8'h00, 8'h00}, '{`RDTC_OFF_GATE, 8'hff, 8'h07},
        '{`RDTC_OFF_GATE, 8'h00, 8'h00}, '{`RDTC_OFF_RUN, 8'h04, 8'h00},
        '{20'hf0244, 8'h5a, 8'h00}
    };

    rdtc_timer u_rdtc_timer (
        .clk                (clk),
        .sys_rst            (sys_rst),
        .clk_en             (1'b1),
        .bus                (bus),
        .rdata              (rdata),
        .low_speed_tick     (low_speed_tick),
        .sub_clock_tick     (1'b0),
        .event_link_unit    (1'b0),
        .gate_interrupt_pin (gate_interrupt_pin),
        .gates              (gates),
        .bidir_timer_pin_i  (pin_i),
        .bidir_timer_pin_o  (pin_o),
        .bidir_timer_pin_oe (pin_oe),
        .port_level         (port_level),
        .timer_out_pin      (timer_out_pin),
        .reload_counter     (reload_counter),
        .underflow_irq      (underflow_irq),
        .edge_irq           (edge_irq)
    );

    rdtc_pin_model u_rdtc_pin_model (
        .clk    (clk),
        .pin_o  (pin_o),
        .pin_oe (pin_oe),
        .pin_i  (pin_i)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // The pulses are one cycle wide, so they are counted away from the active edge.
    always @(negedge clk) begin
        if (underflow_irq === 1'b1) uf_cnt++;
        if (edge_irq === 1'b1) ed_cnt++;
    end

    // ------------------------------------------------------------
    // Bus and checking tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [19:0] a, input logic [7:0] v);
        @(posedge clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge clk);
        bus.wr <= 1'b0;
        @(negedge clk);
    endtask : wr

    task automatic rd(input logic [19:0] a, output logic [7:0] v);
        @(posedge clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        bus.rd <= 1'b0;
        @(negedge clk);
        v = rdata;
    endtask : rd

    task automatic rchk(input logic [19:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk($sformatf("register %h", a), {8'h00, exp}, {8'h00, v});
    endtask : rchk

    // Changes mode only after a forced stop, so software ordering is kept.
    task automatic setup(input logic [7:0] io, input logic [7:0] md, input logic [7:0] gt);
        wr(`RDTC_OFF_RUN, 8'h04);
        wr(`RDTC_OFF_IO, io);
        wr(`RDTC_OFF_GATE, gt);
        wr(`RDTC_OFF_MODE, md);
        wr(`RDTC_OFF_RUN, 8'h01);
        u_rdtc_pin_model.pulse(2, 8);
    endtask : setup

    task automatic ev(input int n, input int w, input int exp);
        @(negedge clk);
        c0 = reload_counter;
        u_rdtc_pin_model.pulse(n, w);
        repeat (4) @(negedge clk);
        chk("event count", c0 - 16'(exp), reload_counter);
    endtask : ev

    task automatic final_report;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report

    initial begin
        repeat (90000) @(posedge clk);
        num_errors++;
        final_report();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        bus = '0;
        gate_interrupt_pin = 1'b0;
        low_speed_tick = 1'b0;
        gates = '0;
        port_level = 1'b0;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        chk("counter", 16'hffff, reload_counter);
        chk("out pin", 16'h0, 16'(timer_out_pin));
        for (int a = 0; a < 4; a++) rchk(20'(`RDTC_OFF_RUN + a), 8'h00);
        foreach (rows[k]) begin
            wr(rows[k].addr, rows[k].wdata);
            rchk(rows[k].addr, rows[k].rexp);
        end
        wr(`RDTC_OFF_IO, 8'h04);
        wr(`RDTC_OFF_MODE, 8'h01);
        chk("out pin", 16'h0, 16'(timer_out_pin));
        chk("pin level", 16'h1, 16'(pin_o));
        wr(`RDTC_OFF_RUN, 8'h01);
        repeat (4) @(posedge clk);
        rchk(`RDTC_OFF_RUN, 8'h03);
        i = 0;
        while (uf_cnt == 0 && i < 70000) begin
            @(posedge clk);
            i++;
        end
        chk("underflows", 16'h1, 16'(uf_cnt));
        rchk(`RDTC_OFF_RUN, 8'h23);
        chk("out pin", 16'h1, 16'(timer_out_pin));
        wr(`RDTC_OFF_RUN, 8'h21);
        rchk(`RDTC_OFF_RUN, 8'h23);
        wr(`RDTC_OFF_RUN, 8'h01);
        rchk(`RDTC_OFF_RUN, 8'h03);
        wr(`RDTC_OFF_RUN, 8'h04);
        rchk(`RDTC_OFF_RUN, 8'h00);
        chk("counter", 16'hffff, reload_counter);
        chk("out pin", 16'h0, 16'(timer_out_pin));
        wr(`RDTC_OFF_IO, 8'h05);
        wr(`RDTC_OFF_MODE, 8'h01);
        chk("out pin", 16'h1, 16'(timer_out_pin));
        chk("pin level", 16'h0, 16'(pin_o));
        chk("pin enable", 16'h1, 16'(pin_oe));
        wr(`RDTC_OFF_IO, 8'h00);
        @(posedge clk) port_level <= 1'b1;
        @(negedge clk) chk("out pin", 16'h1, 16'(timer_out_pin));
        @(posedge clk) port_level <= 1'b0;
        @(negedge clk) chk("out pin", 16'h0, 16'(timer_out_pin));
        // A divided source is selected, yet event mode must still count pin edges.
        setup(8'h00, 8'h12, 8'h00);
        ev(3, 8, 3);
        setup(8'h00, 8'h0a, 8'h00);
        ev(2, 8, 4);
        setup(8'h10, 8'h02, 8'h00);
        ev(3, 2, 0);
        ev(2, 8, 2);
        setup(8'h40, 8'h02, 8'h04);
        ev(2, 8, 0);
        @(posedge clk) gate_interrupt_pin <= 1'b1;
        u_rdtc_pin_model.pulse(2, 8);
        ev(2, 8, 2);
        setup(8'h40, 8'h02, 8'h00);
        ev(2, 8, 0);
        @(posedge clk) gates <= 4'b0100;
        setup(8'h80, 8'h02, 8'h05);
        ev(2, 8, 2);
        @(posedge clk) gates <= 4'b1011;
        ev(2, 8, 0);
        // The shared clock-select bit is taken as set before the slow source is chosen.
        setup(8'h00, 8'h40, 8'h00);
        @(negedge clk);
        c0 = reload_counter;
        repeat (4) begin
            @(posedge clk) low_speed_tick <= 1'b1;
            repeat (4) @(posedge clk);
            low_speed_tick <= 1'b0;
            repeat (4) @(posedge clk);
        end
        @(negedge clk);
        chk("slow source count", c0 - 16'h0003, reload_counter);
        setup(8'h01, 8'h03, 8'h00);
        wr(`RDTC_OFF_RUN, 8'h01);
        ev(1, 8, 8);
        rchk(`RDTC_OFF_RUN, 8'h13);
        setup(8'h00, 8'h04, 8'h00);
        rd(`RDTC_OFF_RUN, d);
        chk("edge flag", 16'h10, {8'h00, d & 8'h10});
        chk("edge pulses", 16'h1, 16'(ed_cnt > 0));
        wr(`RDTC_OFF_RUN, 8'h01);
        rchk(`RDTC_OFF_RUN, 8'h03);
        final_report();
    end
endmodule : reload_down_timer_control_bench
`default_nettype wire
